//--- pkg/sys_pkg.sv
package sys_pkg;
	// ------------------------------------------------------------------
	// Device register offsets on the link (16-bit address)
	// ------------------------------------------------------------------
	localparam logic [15:0] ADDR_BREAK_EXIT   = 16'hfe00; // Break exit status
	localparam logic [15:0] ADDR_RESET_CAUSE  = 16'hfe01; // Reset cause status
	localparam logic [15:0] ADDR_BREAK_CLEAR  = 16'hfe02; // Break clear control

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int          BIT_LP_EXIT      = 1;     // Break ended stop/wait
	localparam int          BIT_CLEAR_EN     = 7;     // Break clear enable
	localparam int          BIT_POR          = 7;     // Power-on cause
	localparam int          BIT_PIN          = 6;     // External pin cause
	localparam int          BIT_WDOG         = 5;     // Watchdog cause
	localparam int          BIT_BAD_OP       = 4;     // Bad opcode cause
	localparam int          BIT_BAD_FETCH    = 3;     // Bad fetch address cause
	localparam int          BIT_LOW_SUPPLY   = 1;     // Low supply cause
	localparam logic [7:0]  CAUSE_RESET_VAL  = 8'h80; // Power-on flag only
	localparam logic [7:0]  BYTE_ZERO        = 8'h00; // Cleared register

	// ------------------------------------------------------------------
	// Reset source lanes on the link
	// ------------------------------------------------------------------
	localparam int          SRC_PIN          = 0;
	localparam int          SRC_WDOG         = 1;
	localparam int          SRC_BAD_OP       = 2;
	localparam int          SRC_BAD_FETCH    = 3;
	localparam int          SRC_LOW_SUPPLY   = 4;
	localparam int          SRC_COUNT        = 5;

	// ------------------------------------------------------------------
	// Stop recovery timing, in reference clock cycles
	// ------------------------------------------------------------------
	localparam int          RECOV_FULL_XCLK  = 4096; // Normal recovery
	localparam int          RECOV_SHORT_XCLK = 32;   // Short recovery
	localparam int          CLK_PER_XCLK     = 1;    // Reference clock is clk
	localparam logic [11:0] RECOV_FULL_LAST  = 12'(RECOV_FULL_XCLK * CLK_PER_XCLK - 1);
	localparam logic [11:0] RECOV_SHORT_LAST = 12'(RECOV_SHORT_XCLK * CLK_PER_XCLK - 1);

	// ------------------------------------------------------------------
	// Controller AHB-Lite register byte offsets
	// ------------------------------------------------------------------
	localparam logic [3:0]  OFS_CTRL         = 4'h0; // Config
	localparam logic [3:0]  OFS_EVENT        = 4'h4; // Event strobes
	localparam logic [3:0]  OFS_ACCESS       = 4'h8; // Device register access
	localparam logic [3:0]  OFS_STATUS       = 4'hc; // Status
	localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;

	// Power-mode state of the device
	typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER} lp_state_t;
endpackage : sys_pkg

//--- pkg/sys_link_if.sv
interface sys_link_if;
	logic        reg_req;             // Register access strobe
	logic        reg_wr;              // Access is a write
	logic [15:0] reg_addr;            // Register address
	logic [7:0]  reg_wdata;           // Write data
	logic [7:0]  reg_rdata;           // Read data
	logic        reg_ack;             // Access done strobe
	logic        stop_enter;          // Stop instruction executed
	logic        wait_enter;          // Wait instruction executed
	logic        wake_req;            // Interrupt wake request
	logic        break_req;           // Break source request
	logic        break_end;           // Break routine returned
	logic [4:0]  rst_src;             // Reset source strobes
	logic        fetch_access;        // Bad address came from opcode fetch
	logic        short_stop_recovery; // Short recovery config
	logic        break_int;           // Break interrupt strobe
	logic        break_state;         // In break state
	logic        cpu_hold;            // CPU clocks held
	logic        recovering;          // Stop recovery running
	logic        flag_clear_allow;    // Peripheral flags clearable

	modport dev (
		input  reg_req, reg_wr, reg_addr, reg_wdata, stop_enter, wait_enter,
		input  wake_req, break_req, break_end, rst_src, fetch_access, short_stop_recovery,
		output reg_rdata, reg_ack, break_int, break_state, cpu_hold, recovering,
		output flag_clear_allow
	);
	modport ctl (
		output reg_req, reg_wr, reg_addr, reg_wdata, stop_enter, wait_enter,
		output wake_req, break_req, break_end, rst_src, fetch_access, short_stop_recovery,
		input  reg_rdata, reg_ack, break_int, break_state, cpu_hold, recovering,
		input  flag_clear_allow
	);
endinterface : sys_link_if

//--- src/sim_reset_break_status.sv
module sim_reset_break_status
	import sys_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	sys_link_if.dev   link
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	lp_state_t   state;             // Power mode
	lp_state_t   next_state;        // Power mode next
	logic [11:0] sys_count;         // System counter
	logic [11:0] recov_last;        // Last count of recovery
	logic        recov_done;        // Recovery period over
	logic        break_pending;     // Break waits for recovery end
	logic        break_fire;        // Break interrupt this cycle
	logic        lp_break;          // Break ends stop or wait
	logic        next_break_state;  // Break state next
	logic        break_state_q;     // Break state
	logic        lp_exit_flag;      // Break lowpower exit flag
	logic        clear_enable;      // Break clear enable bit
	logic        next_clear_enable; // Clear enable next
	logic [7:0]  cause;             // Reset cause flags
	logic [7:0]  cause_set;         // New cause bits
	logic [4:0]  src_hit;           // Qualified reset sources
	logic        any_rst;           // Some reset source fired
	logic        rd_hit;            // Read strobe
	logic        wr_hit;            // Write strobe
	logic [7:0]  rd_mux;            // Read data select

	// ------------------------------------------------------------------
	// Reset sources
	// ------------------------------------------------------------------

	// Bad address counts only for opcode fetches
	always_comb begin
		src_hit                = link.rst_src;
		src_hit[SRC_BAD_FETCH] = link.rst_src[SRC_BAD_FETCH] & link.fetch_access;
		any_rst                = |src_hit;
	end

	// Map each source to its cause bit
	always_comb begin
		cause_set                 = BYTE_ZERO;
		cause_set[BIT_PIN]        = src_hit[SRC_PIN];
		cause_set[BIT_WDOG]       = src_hit[SRC_WDOG];
		cause_set[BIT_BAD_OP]     = src_hit[SRC_BAD_OP];
		cause_set[BIT_BAD_FETCH]  = src_hit[SRC_BAD_FETCH];
		cause_set[BIT_LOW_SUPPLY] = src_hit[SRC_LOW_SUPPLY];
	end

	// ------------------------------------------------------------------
	// Stop recovery timing
	// ------------------------------------------------------------------

	// Recovery length from config bit; crystal users keep it clear
	always_comb begin
		recov_last = link.short_stop_recovery ? RECOV_SHORT_LAST : RECOV_FULL_LAST;
		recov_done = (state == ST_RECOVER) && (sys_count == recov_last);
	end

	// System counter: held at zero in stop, cleared at recovery end, free running elsewhere
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sys_count <= 12'h000;
		end else if (next_state == ST_STOP || state == ST_STOP) begin
			sys_count <= 12'h000;
		end else if (recov_done) begin
			sys_count <= 12'h000;
		end else begin
			sys_count <= sys_count + 12'h001;
		end
	end

	// ------------------------------------------------------------------
	// Power mode sequencing
	// ------------------------------------------------------------------

	// Break wakes stop or wait
	always_comb begin
		lp_break = link.break_req && ((state == ST_WAIT) || (state == ST_STOP));
	end

	// Break interrupt in run or wait, or at end of a stop recovery
	always_comb begin
		break_fire = (!break_state_q && link.break_req
		             && ((state == ST_RUN) || (state == ST_WAIT)))
		           || (recov_done && (break_pending || link.break_req));
	end

	// Next power mode
	always_comb begin
		next_state = state;
		unique case (state)
			ST_RUN: begin
				// Break beats a stop or wait in the same cycle
				if (break_fire) begin
					next_state = ST_RUN;
				end else if (link.stop_enter) begin
					next_state = ST_STOP;
				end else if (link.wait_enter) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (link.wake_req || link.break_req) begin
					next_state = ST_RUN;
				end
			end
			ST_STOP: begin
				if (link.wake_req || link.break_req) begin
					next_state = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				if (recov_done) begin
					next_state = ST_RUN;
				end
			end
		endcase
		if (any_rst) begin
			next_state = ST_RUN;
		end
	end

	// Mode register and its status outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state           <= ST_RUN;
			link.cpu_hold   <= 1'b0;
			link.recovering <= 1'b0;
		end else begin
			state           <= next_state;
			link.cpu_hold   <= (next_state != ST_RUN);
			link.recovering <= (next_state == ST_RECOVER);
		end
	end

	// ------------------------------------------------------------------
	// Break state
	// ------------------------------------------------------------------

	// Break held until return or reset
	always_comb begin
		next_break_state = break_state_q;
		if (any_rst || link.break_end) begin
			next_break_state = 1'b0;
		end
		if (break_fire && !any_rst) begin
			next_break_state = 1'b1;
		end
	end

	// Break taken in stop waits for recovery to finish
	always_ff @(posedge clk) begin
		if (!rst_b || any_rst) begin
			break_pending <= 1'b0;
		end else if (recov_done) begin
			break_pending <= 1'b0;
		end else if (link.break_req && (state == ST_STOP || state == ST_RECOVER)) begin
			break_pending <= 1'b1;
		end
	end

	// Break strobe and state outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			break_state_q    <= 1'b0;
			link.break_state <= 1'b0;
			link.break_int   <= 1'b0;
		end else begin
			break_state_q    <= next_break_state;
			link.break_state <= next_break_state;
			link.break_int   <= break_fire && !any_rst;
		end
	end

	// ------------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------------

	// Access strobes
	always_comb begin
		rd_hit = link.reg_req && !link.reg_wr;
		wr_hit = link.reg_req && link.reg_wr;
	end

	// Read data select; unmapped reads zero
	always_comb begin
		rd_mux = BYTE_ZERO;
		if (link.reg_addr == ADDR_BREAK_EXIT) begin
			rd_mux[BIT_LP_EXIT] = lp_exit_flag;
		end else if (link.reg_addr == ADDR_RESET_CAUSE) begin
			rd_mux = cause;
		end else if (link.reg_addr == ADDR_BREAK_CLEAR) begin
			rd_mux[BIT_CLEAR_EN] = clear_enable;
		end
	end

	// Read data and done strobe one cycle after request
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			link.reg_rdata <= BYTE_ZERO;
			link.reg_ack   <= 1'b0;
		end else begin
			link.reg_ack <= link.reg_req;
			if (rd_hit) begin
				link.reg_rdata <= rd_mux;
			end
		end
	end

	// Break lowpower exit flag; set wins over the zero write
	always_ff @(posedge clk) begin
		if (!rst_b || any_rst) begin
			lp_exit_flag <= 1'b0;
		end else if (lp_break) begin
			lp_exit_flag <= 1'b1;
		end else if (wr_hit && link.reg_addr == ADDR_BREAK_EXIT
		             && !link.reg_wdata[BIT_LP_EXIT]) begin
			lp_exit_flag <= 1'b0;
		end
	end

	// Reset cause flags; new cause wins over read clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cause <= CAUSE_RESET_VAL;
		end else if (rd_hit && link.reg_addr == ADDR_RESET_CAUSE) begin
			cause <= cause_set;
		end else begin
			cause <= cause | cause_set;
		end
	end

	// Break clear enable next value
	always_comb begin
		next_clear_enable = clear_enable;
		if (any_rst) begin
			next_clear_enable = 1'b0;
		end else if (wr_hit && link.reg_addr == ADDR_BREAK_CLEAR) begin
			next_clear_enable = link.reg_wdata[BIT_CLEAR_EN];
		end
	end

	// Clear enable and peripheral flag protection output
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			clear_enable          <= 1'b0;
			link.flag_clear_allow <= 1'b1;
		end else begin
			clear_enable          <= next_clear_enable;
			link.flag_clear_allow <= !next_break_state || next_clear_enable;
		end
	end

endmodule : sim_reset_break_status

//--- src/sim_core_ctl.sv
// Controller end: software drives the link through AHB-Lite
module sim_core_ctl
	import sys_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	sys_link_if.ctl          link
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic        pend;       // Data phase in progress
	logic        pend_wr;    // Data phase is a write
	logic [31:0] pend_addr;  // Latched address
	logic        mapped;     // Address inside block
	logic        busy;       // Device access outstanding
	logic [7:0]  last_rdata; // Last device read data
	logic        break_seen; // Sticky break strobe
	logic        wr_do;      // Write applied now
	logic        rd_do;      // Read applied now
	logic [31:0] rd_mux;     // Read data select

	// ------------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------------

	// Decode of latched address; hsize is always a word
	always_comb begin
		mapped = (pend_addr[31:4] == 28'h0000000);
		wr_do  = pend && !hreadyout && pend_wr && mapped;
		rd_do  = pend && !hreadyout && !pend_wr;
	end

	// Address phase capture, one wait state, then OKAY
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pend      <= 1'b0;
			pend_wr   <= 1'b0;
			pend_addr <= WORD_ZERO;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (pend && !hreadyout) begin
			hreadyout <= 1'b1;
		end else if (hsel && htrans[1] && hready) begin
			pend      <= 1'b1;
			pend_wr   <= hwrite;
			pend_addr <= haddr;
			hreadyout <= 1'b0;
		end else begin
			pend <= 1'b0;
		end
	end

	// Read data select
	always_comb begin
		rd_mux = WORD_ZERO;
		if (mapped) begin
			unique case (pend_addr[3:0])
				OFS_CTRL: begin
					rd_mux[0] = link.short_stop_recovery;
				end
				OFS_STATUS: begin
					rd_mux[7:0] = last_rdata;
					rd_mux[8]   = busy;
					rd_mux[9]   = break_seen;
					rd_mux[10]  = link.break_state;
					rd_mux[11]  = link.cpu_hold;
					rd_mux[12]  = link.recovering;
					rd_mux[13]  = link.flag_clear_allow;
				end
				default: begin
					rd_mux = WORD_ZERO;
				end
			endcase
		end
	end

	// Read data register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hrdata <= WORD_ZERO;
		end else if (rd_do) begin
			hrdata <= rd_mux;
		end
	end

	// ------------------------------------------------------------------
	// Link drive
	// ------------------------------------------------------------------

	// Config level and one-cycle event strobes
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			link.short_stop_recovery <= 1'b0;
			link.stop_enter          <= 1'b0;
			link.wait_enter          <= 1'b0;
			link.wake_req            <= 1'b0;
			link.break_req           <= 1'b0;
			link.break_end           <= 1'b0;
			link.rst_src             <= 5'h00;
			link.fetch_access        <= 1'b0;
		end else begin
			link.stop_enter   <= wr_do && pend_addr[3:0] == OFS_EVENT && hwdata[0];
			link.wait_enter   <= wr_do && pend_addr[3:0] == OFS_EVENT && hwdata[1];
			link.wake_req     <= wr_do && pend_addr[3:0] == OFS_EVENT && hwdata[2];
			link.break_req    <= wr_do && pend_addr[3:0] == OFS_EVENT && hwdata[3];
			link.break_end    <= wr_do && pend_addr[3:0] == OFS_EVENT && hwdata[4];
			link.rst_src      <= (wr_do && pend_addr[3:0] == OFS_EVENT) ? hwdata[9:5] : 5'h00;
			link.fetch_access <= wr_do && pend_addr[3:0] == OFS_EVENT && hwdata[10];
			if (wr_do && pend_addr[3:0] == OFS_CTRL) begin
				link.short_stop_recovery <= hwdata[0];
			end
		end
	end

	// Device register access: one request, wait for done
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			link.reg_req   <= 1'b0;
			link.reg_wr    <= 1'b0;
			link.reg_addr  <= 16'h0000;
			link.reg_wdata <= 8'h00;
			busy           <= 1'b0;
			last_rdata     <= 8'h00;
		end else begin
			link.reg_req <= 1'b0;
			if (link.reg_ack) begin
				busy <= 1'b0;
				if (!link.reg_wr) begin
					last_rdata <= link.reg_rdata;
				end
			end else if (wr_do && pend_addr[3:0] == OFS_ACCESS && !busy) begin
				link.reg_req   <= 1'b1;
				link.reg_wr    <= hwdata[24];
				link.reg_addr  <= hwdata[15:0];
				link.reg_wdata <= hwdata[23:16];
				busy           <= 1'b1;
			end
		end
	end

	// Sticky break flag; new strobe wins over status read
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			break_seen <= 1'b0;
		end else if (link.break_int) begin
			break_seen <= 1'b1;
		end else if (rd_do && mapped && pend_addr[3:0] == OFS_STATUS) begin
			break_seen <= 1'b0;
		end
	end

endmodule : sim_core_ctl

//--- sim/sim_reset_break_status_asserts.sv
// ------------------------------------------------------------------
// Link-side checker for the status block
// ------------------------------------------------------------------
module sim_reset_break_status_asserts
	import sys_pkg::*;
(
	input logic        clk,
	input logic        rst_b,
	input logic        reg_req,
	input logic        reg_wr,
	input logic [15:0] reg_addr,
	input logic [7:0]  reg_wdata,
	input logic [7:0]  reg_rdata,
	input logic        reg_ack,
	input logic        stop_enter,
	input logic        break_req,
	input logic        break_end,
	input logic [4:0]  rst_src,
	input logic        fetch_access,
	input logic        short_stop_recovery,
	input logic        break_int,
	input logic        break_state,
	input logic        cpu_hold,
	input logic        recovering,
	input logic        flag_clear_allow
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	logic        rst_hit; // Reset source strobe that the device accepts
	logic [12:0] rec_cnt; // Cycles spent recovering
	logic        en_m;    // Expected clear enable
	logic        rd_q;    // Cause read in its answer cycle
	logic        clean;   // Causes read back, none since

	assign rst_hit = |{rst_src[4], rst_src[2:0], rst_src[3] & fetch_access};

	// Recovery length counter
	always_ff @(posedge clk) begin
		if (!rst_b || !recovering)
			rec_cnt <= '0;
		else
			rec_cnt <= rec_cnt + 13'h1;
	end

	// Enable bit as software last wrote it
	always_ff @(posedge clk) begin
		if (!rst_b || rst_hit)
			en_m <= 1'b0;
		else if (reg_req && reg_wr && reg_addr == ADDR_BREAK_CLEAR)
			en_m <= reg_wdata[BIT_CLEAR_EN];
	end

	// Tracks that the cause flags were just read out
	always_ff @(posedge clk) begin
		rd_q <= rst_b && reg_req && !reg_wr && reg_addr == ADDR_RESET_CAUSE && !rst_hit;
		if (!rst_b || rst_hit)
			clean <= 1'b0;
		else if (rd_q)
			clean <= 1'b1;
	end

	sequence brk_take_s;
		break_req && !break_state && !cpu_hold && !rst_hit;
	endsequence
	sequence brk_on_s;
		break_int && break_state ##1 !break_int;
	endsequence

	ack_once_a: assert property (reg_req |=> reg_ack ##1 !reg_ack)
		else $error("register access not answered in one cycle");
	brk_enter_a: assert property (brk_take_s |=> brk_on_s)
		else $error("break request did not raise break");
	brk_hold_a: assert property (break_state && !break_end && !rst_hit |=> break_state)
		else $error("break state dropped early");
	stop_hold_a: assert property (stop_enter && !cpu_hold && !break_state && !break_req
		&& !rst_hit |=> cpu_hold && !recovering) else $error("stop entry not held");
	recov_len_a: assert property ($fell(recovering) && !$past(rst_hit) |->
		rec_cnt == (short_stop_recovery ? RECOV_SHORT_XCLK : RECOV_FULL_XCLK) * CLK_PER_XCLK)
		else $error("stop recovery length wrong");
	resume_a: assert property ($fell(recovering) |-> ##[0:1] !cpu_hold)
		else $error("cpu not resumed after recovery");
	clear_gate_a: assert property (flag_clear_allow == (!break_state || en_m))
		else $error("flag clear permission wrong");
	cause_clear_a: assert property (rd_q && clean |-> reg_ack && reg_rdata == BYTE_ZERO)
		else $error("cause flags not cleared by read");
endmodule : sim_reset_break_status_asserts

//--- sim/sim_reset_break_status_test.sv
module sim_reset_break_status_test import sys_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct { string nm; logic [31:0] m; logic [31:0] v; } exp_t;

	// ------------------------------------------------------------------
	// Bench signals
	// ------------------------------------------------------------------
	logic        clk;
	logic        rst_b;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        rd_mark;   // Data phase of a checked read
	exp_t        exp_q[$];  // Expected results in order
	exp_t        e_cur;     // Note being compared
	int          bad_count;
	int          tests_run;
	logic [4:0]  m;         // Reset sources of one pass
	logic        f;         // Fetch qualifier of one pass

	sys_link_if link_bus ();

	sim_reset_break_status sim_reset_break_status_inst (.clk(clk), .rst_b(rst_b), .link(link_bus));
	sim_core_ctl sim_core_ctl_inst (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(), .link(link_bus));
	sim_reset_break_status_asserts asserts_inst (.clk(clk), .rst_b(rst_b),
		.reg_req(link_bus.reg_req), .reg_wr(link_bus.reg_wr), .reg_addr(link_bus.reg_addr),
		.reg_wdata(link_bus.reg_wdata), .reg_rdata(link_bus.reg_rdata),
		.reg_ack(link_bus.reg_ack), .stop_enter(link_bus.stop_enter),
		.break_req(link_bus.break_req), .break_end(link_bus.break_end),
		.rst_src(link_bus.rst_src), .fetch_access(link_bus.fetch_access),
		.short_stop_recovery(link_bus.short_stop_recovery), .break_int(link_bus.break_int),
		.break_state(link_bus.break_state), .cpu_hold(link_bus.cpu_hold),
		.recovering(link_bus.recovering), .flag_clear_allow(link_bus.flag_clear_allow));

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask : check

	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// One single AHB transfer, address phase then data phase
	task automatic xfer(logic [31:0] a, logic w, logic [31:0] d, logic chk, output logic [31:0] r);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		rd_mark <= chk;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		rd_mark <= 1'b0;
	endtask : xfer

	task automatic wr(logic [3:0] o, logic [31:0] d);
		logic [31:0] r;
		xfer({28'h0, o}, 1'b1, d, 1'b0, r);
	endtask : wr

	task automatic expect_st(string nm, logic [31:0] mk, logic [31:0] v);
		logic [31:0] r;
		exp_q.push_back('{nm, mk, v});
		xfer({28'h0, OFS_STATUS}, 1'b0, WORD_ZERO, 1'b1, r);
	endtask : expect_st

	// Device access through the controller, polled until not busy
	task automatic dev(logic [15:0] a, logic w, logic [7:0] d);
		logic [31:0] r;
		int          n;
		wr(OFS_ACCESS, {7'h0, w, d, a});
		r = 32'h100;
		n = 0;
		while (r[8] !== 1'b0 && n < 50) begin
			xfer({28'h0, OFS_STATUS}, 1'b0, WORD_ZERO, 1'b0, r);
			n++;
		end
		if (r[8] !== 1'b0) bad_count++;
	endtask : dev

	task automatic dev_chk(string nm, logic [15:0] a, logic [7:0] v);
		dev(a, 1'b0, 8'h00);
		expect_st(nm, 32'hff, {24'h0, v});
	endtask : dev_chk

	// Event strobes, then let them land
	task automatic ev(logic [10:0] b);
		wr(OFS_EVENT, {21'h0, b});
		repeat (2) @(posedge clk);
	endtask : ev

	task automatic wait_run();
		int n;
		n = 0;
		while (link_bus.cpu_hold !== 1'b0 && n < 6000) begin
			@(posedge clk);
			n++;
		end
		if (link_bus.cpu_hold !== 1'b0) bad_count++;
	endtask : wait_run

	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
	endtask : do_reset

	// ------------------------------------------------------------------
	// Clock, monitor, watchdog
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Compares each checked read against the oldest note
	always @(posedge clk) begin
		if (rd_mark === 1'b1 && hready === 1'b1 && exp_q.size() > 0) begin
			e_cur = exp_q.pop_front();
			check(e_cur.nm, hrdata & e_cur.m, e_cur.v);
		end
	end

	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		results();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		{rst_b, haddr, htrans, hwrite, hwdata, rd_mark} = '0;
		hsel = 1'b1;
		hsize = 3'b010;
		void'($urandom(32'ha5aac420));
		do_reset();
		dev_chk("cause por", ADDR_RESET_CAUSE, CAUSE_RESET_VAL);
		dev_chk("cause read", ADDR_RESET_CAUSE, BYTE_ZERO);
		dev_chk("exit reset", ADDR_BREAK_EXIT, BYTE_ZERO);
		$display("test power_on done");
		for (int i = 0; i < 10; i++) begin
			m = (i < 5) ? 5'(1 << i) : (i == 5) ? 5'h08 : 5'($urandom);
			f = (i < 5) ? 1'b1 : (i == 5) ? 1'b0 : 1'($urandom);
			ev({f, m, 5'h00});
			dev_chk("cause src", ADDR_RESET_CAUSE, {1'b0, m[0], m[1], m[2], m[3] & f, 1'b0, m[4], 1'b0});
			dev_chk("cause again", ADDR_RESET_CAUSE, BYTE_ZERO);
		end
		$display("test sources done");
		dev(ADDR_BREAK_CLEAR, 1'b1, 8'hff);
		dev_chk("enable", ADDR_BREAK_CLEAR, 8'h80);
		ev(11'h008);
		expect_st("break on", 32'h3e00, 32'h2600);
		dev(ADDR_BREAK_CLEAR, 1'b1, 8'h00);
		expect_st("break guard", 32'h3c00, 32'h0400);
		ev(11'h010);
		expect_st("break off", 32'h3c00, 32'h2000);
		$display("test break done");
		ev(11'h002);
		ev(11'h004);
		dev_chk("wake only", ADDR_BREAK_EXIT, BYTE_ZERO);
		ev(11'h002);
		ev(11'h008);
		dev_chk("wait break", ADDR_BREAK_EXIT, 8'h02);
		dev(ADDR_BREAK_EXIT, 1'b1, 8'hff);
		dev_chk("one write", ADDR_BREAK_EXIT, 8'h02);
		ev(11'h012);
		expect_st("wait again", 32'h0c00, 32'h0800);
		ev(11'h020);
		dev_chk("reset clears", ADDR_BREAK_EXIT, BYTE_ZERO);
		$display("test wait done");
		wr(OFS_CTRL, 32'h1);
		ev(11'h001);
		expect_st("stopped", 32'h1800, 32'h0800);
		ev(11'h008);
		expect_st("recovering", 32'h1800, 32'h1800);
		wait_run();
		dev_chk("stop break", ADDR_BREAK_EXIT, 8'h02);
		ev(11'h010);
		dev(ADDR_BREAK_EXIT, 1'b1, 8'h00);
		dev_chk("zero write", ADDR_BREAK_EXIT, BYTE_ZERO);
		wr(OFS_CTRL, WORD_ZERO);
		ev(11'h001);
		ev(11'h004);
		wait_run();
		dev_chk("stop wake", ADDR_BREAK_EXIT, BYTE_ZERO);
		$display("test stop done");
		ev(11'h020);
		do_reset();
		dev_chk("por again", ADDR_RESET_CAUSE, CAUSE_RESET_VAL);
		$display("test reset done");
		results();
	end
endmodule : sim_reset_break_status_test
